// file: hw/swt_pkg.sv
package swt_pkg;

  // register byte addresses of the watchdog block
  localparam logic [31:0] SWT_RELOAD_ADDR  = 32'hffff0360;
  localparam logic [31:0] SWT_COUNT_ADDR   = 32'hffff0364;
  localparam logic [31:0] SWT_CONTROL_ADDR = 32'hffff0368;
  localparam logic [31:0] SWT_CLEAR_ADDR   = 32'hffff036c;

  // register index on the device port (byte address bits 3:2)
  localparam logic [1:0] SWT_IDX_RELOAD  = SWT_RELOAD_ADDR[3:2];
  localparam logic [1:0] SWT_IDX_COUNT   = SWT_COUNT_ADDR[3:2];
  localparam logic [1:0] SWT_IDX_CONTROL = SWT_CONTROL_ADDR[3:2];
  localparam logic [1:0] SWT_IDX_CLEAR   = SWT_CLEAR_ADDR[3:2];

  // reset values
  localparam logic [15:0] SWT_RELOAD_RST  = 16'h03d7;
  localparam logic [15:0] SWT_COUNT_RST   = 16'h03d7;
  localparam logic [8:0]  SWT_CONTROL_RST = 9'h000;
  localparam logic [7:0]  SWT_CLEAR_RST   = 8'h00;

  // control field positions
  localparam int SWT_CTL_UP       = 8;
  localparam int SWT_CTL_ENABLE   = 7;
  localparam int SWT_CTL_PERIODIC = 6;
  localparam int SWT_CTL_WATCHDOG = 5;
  localparam int SWT_CTL_SECURE   = 4;
  localparam int SWT_CTL_PRE_HI   = 3;
  localparam int SWT_CTL_PRE_LO   = 2;
  localparam int SWT_CTL_IRQ_EN   = 1;
  localparam int SWT_CTL_PD_STOP  = 0;
  localparam logic [15:0] SWT_CTL_WMASK = 16'h01ff;
  localparam logic [1:0]  SWT_PRE_DIV1  = 2'h0;

  // lfsr low taps of x8+x6+x5+x+1
  localparam logic [7:0] SWT_LFSR_TAPS = 8'h63;

  // controller apb map
  localparam logic [7:0] SWT_APB_ACCESS = 8'h00;
  localparam logic [7:0] SWT_APB_RESULT = 8'h04;
  localparam logic [7:0] SWT_APB_STATUS = 8'h08;
  localparam logic [7:0] SWT_APB_SYSCTL = 8'h0c;
  localparam int SWT_ACC_WR_BIT  = 16;
  localparam int SWT_ACC_IDX_LO  = 17;
  localparam int SWT_ST_DONE     = 0;
  localparam int SWT_ST_RST_SEEN = 1;
  localparam int SWT_ST_IRQ      = 2;
  localparam int SWT_ST_ACTIVE   = 3;
  localparam int SWT_SC_PD       = 0;
  localparam int SWT_SC_DBG      = 1;

  // timing
  localparam int SWT_CLK_HZ      = 125_000_000;
  localparam int SWT_LF_HZ       = 32_768;
  localparam int SWT_LF_HALF_CYC = SWT_CLK_HZ / (2 * SWT_LF_HZ);

endpackage

// file: hw/swt_if.sv
`timescale 1ns/1ps
interface swt_if;
  logic        acc_req;
  logic        acc_wr;
  logic [1:0]  acc_idx;
  logic [15:0] acc_wdata;
  logic        acc_ack;
  logic [15:0] acc_rdata;
  logic        lf_clk;
  logic        powerdown;
  logic        debug_halt;
  logic        sys_rst;
  logic        wd_reset_req;
  logic        wd_irq;

  modport dev
  (
    input  acc_req, acc_wr, acc_idx, acc_wdata, lf_clk, powerdown, debug_halt, sys_rst,
    output acc_ack, acc_rdata, wd_reset_req, wd_irq
  );
  modport host
  (
    output acc_req, acc_wr, acc_idx, acc_wdata, lf_clk, powerdown, debug_halt, sys_rst,
    input  acc_ack, acc_rdata, wd_reset_req, wd_irq
  );
endinterface

// file: hw/swt_device.sv
// Function
// - sixteen bit reload register, resets 0x03d7
// - read only count register, resets 0x03d7
// - clear write drops interrupt or restarts timeout
// - control bit 8 picks up or down
// - control bit 7 enables counting and events
// - bit 6 periodic reload, else free wrap
// - bit 5 selects watchdog mode
// - bit 4 secure clear, watchdog only
// - prescaler bits 3:2, code 00 divides one
// - bit 1 irq instead of reset
// - bit 0 stops counter in powerdown
// - software writes zero to reserved bits
// - eight bit lfsr gives service values
// - clear write before watchdog seeds lfsr
// - matching service reloads, lfsr steps
// - mismatching service causes immediate reset
// - zero seed forces reset at every secure service
// - lfsr state is never readable
// - watchdog counts down, zero fires event
// - watchdog locks reload and control registers
// - reload on overflow when periodic or in watchdog, and on clear write except a mismatching or zero-seed secure service
// - counter pauses during debug halt
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module swt_device
  import swt_pkg::*;
(
  // system
  input  wire logic clk,
  input  wire logic rst_b,
  // link to controller
  swt_if.dev        link,
  // user side
  output logic      wd_active
);

  typedef struct packed {
    logic [15:0] reload;
    logic [15:0] count;
    logic [8:0]  ctrl;
    logic [7:0]  lfsr;
    logic        locked;
    logic        irq_pend;
    logic        rst_req;
    logic        lf_s1;
    logic        lf_s2;
    logic        lf_prev;
    logic        ack;
    logic [15:0] rdata;
  } swt_dev_state_type;

  swt_dev_state_type state_reg;
  swt_dev_state_type state_next;

  // lfsr next state
  function automatic logic [7:0] swt_lfsr_step(input logic [7:0] v);
    swt_lfsr_step = {v[6:0], 1'b0} ^ (v[7] ? SWT_LFSR_TAPS : 8'h00);
  endfunction

  logic tick;
  logic run;
  logic wd_mode;
  logic at_limit;
  logic clr_wr;

  // next state
  always_comb
  begin
    state_next = state_reg;
    state_next.lf_s1   = link.lf_clk;
    state_next.lf_s2   = state_reg.lf_s1;
    state_next.lf_prev = state_reg.lf_s2;
    state_next.ack     = 1'b0;
    state_next.rst_req = 1'b0;
    // only divide by one exists; reserved codes behave the same
    tick = state_reg.lf_s2 & ~state_reg.lf_prev;
    wd_mode = state_reg.ctrl[SWT_CTL_WATCHDOG];
    run = state_reg.ctrl[SWT_CTL_ENABLE]
          & ~link.debug_halt
          & ~(state_reg.ctrl[SWT_CTL_PD_STOP] & link.powerdown);
    clr_wr = link.acc_req & link.acc_wr & (link.acc_idx == SWT_IDX_CLEAR);
    if (wd_mode)
      at_limit = (state_reg.count == 16'h0000);
    else if (state_reg.ctrl[SWT_CTL_UP])
      at_limit = (state_reg.count == 16'hffff);
    else
      at_limit = (state_reg.count == 16'h0000);

    // counting
    if (tick && run)
    begin
      if (wd_mode)
      begin
        if (at_limit)
        begin
          state_next.count = state_reg.reload;
          if (state_reg.ctrl[SWT_CTL_IRQ_EN])
            state_next.irq_pend = 1'b1;
          else
            state_next.rst_req = 1'b1;
        end
        else
          state_next.count = state_reg.count - 16'h0001;
      end
      else
      begin
        if (at_limit)
        begin
          state_next.irq_pend = 1'b1;
          if (state_reg.ctrl[SWT_CTL_PERIODIC])
            state_next.count = state_reg.reload;
          else if (state_reg.ctrl[SWT_CTL_UP])
            state_next.count = 16'h0000;
          else
            state_next.count = 16'hffff;
        end
        else if (state_reg.ctrl[SWT_CTL_UP])
          state_next.count = state_reg.count + 16'h0001;
        else
          state_next.count = state_reg.count - 16'h0001;
      end
    end

    // register writes
    if (link.acc_req && link.acc_wr && !state_reg.locked)
    begin
      if (link.acc_idx == SWT_IDX_RELOAD)
        state_next.reload = link.acc_wdata;
      if (link.acc_idx == SWT_IDX_CONTROL)
      begin
        state_next.ctrl = link.acc_wdata[8:0];
        if (link.acc_wdata[SWT_CTL_WATCHDOG])
          state_next.locked = 1'b1;
      end
    end

    // service writes
    if (clr_wr)
    begin
      if (!wd_mode)
      begin
        state_next.lfsr = link.acc_wdata[7:0];
        state_next.count = state_reg.reload;
        // an event in this very cycle wins over the clear
        if (!(tick && run && at_limit))
          state_next.irq_pend = 1'b0;
      end
      else if (state_reg.ctrl[SWT_CTL_SECURE])
      begin
        if (link.acc_wdata[7:0] == state_reg.lfsr && state_reg.lfsr != 8'h00)
        begin
          state_next.count = state_reg.reload;
          state_next.lfsr = swt_lfsr_step(state_reg.lfsr);
        end
        else
          state_next.rst_req = 1'b1;
      end
      else
        state_next.count = state_reg.reload;
    end

    // read answers; lfsr has no read path
    if (link.acc_req)
    begin
      state_next.ack = 1'b1;
      unique case (link.acc_idx)
        SWT_IDX_RELOAD:  state_next.rdata = state_reg.reload;
        SWT_IDX_COUNT:   state_next.rdata = state_reg.count;
        SWT_IDX_CONTROL: state_next.rdata = {7'h00, state_reg.ctrl};
        SWT_IDX_CLEAR:   state_next.rdata = 16'h0000;
      endcase
    end

    // a non power-on reset only touches an unlocked block
    if (link.sys_rst && !state_reg.locked)
    begin
      state_next.reload   = SWT_RELOAD_RST;
      state_next.count    = SWT_COUNT_RST;
      state_next.ctrl     = SWT_CONTROL_RST;
      state_next.irq_pend = 1'b0;
    end
  end

  // state register, rst_b is the power-on reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.reload <= SWT_RELOAD_RST;
      state_reg.count  <= SWT_COUNT_RST;
      state_reg.ctrl   <= SWT_CONTROL_RST;
      state_reg.lfsr   <= SWT_CLEAR_RST;
    end
    else
      state_reg <= state_next;
  end

  // outputs
  assign link.acc_ack      = state_reg.ack;
  assign link.acc_rdata    = state_reg.rdata;
  assign link.wd_reset_req = state_reg.rst_req;
  assign link.wd_irq       = state_reg.irq_pend;
  assign wd_active         = state_reg.locked;

endmodule

// file: hw/swt_ctrl.sv
`timescale 1ns/1ps
module swt_ctrl
  import swt_pkg::*;
#(
  parameter int LF_HALF_CYC = SWT_LF_HALF_CYC
)
(
  // system
  input  wire logic        clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link to watchdog
  swt_if.host              link
);

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        req;
    logic        wr;
    logic [1:0]  idx;
    logic [15:0] wdata;
    logic [15:0] result;
    logic        done;
    logic        rst_seen;
    logic        pd;
    logic        dbg;
    logic        sys_rst;
    logic        lf;
    logic [11:0] div;
    logic        active;
  } swt_ctrl_state_type;

  swt_ctrl_state_type state_reg;
  swt_ctrl_state_type state_next;
  logic setup;
  logic wr_en;

  // next state
  always_comb
  begin
    state_next = state_reg;
    state_next.req = 1'b0;
    state_next.sys_rst = link.wd_reset_req;
    setup = psel & ~penable;
    wr_en = psel & penable & pwrite & state_reg.pready;
    state_next.pready = setup;
    // low frequency clock made by a divider
    if (state_reg.div == 12'(LF_HALF_CYC - 1))
    begin
      state_next.div = 12'h000;
      state_next.lf = ~state_reg.lf;
    end
    else
      state_next.div = state_reg.div + 12'h001;
    if (link.acc_ack)
    begin
      state_next.result = link.acc_rdata;
      state_next.done = 1'b1;
    end
    if (link.acc_ack && state_reg.wr && state_reg.idx == SWT_IDX_CONTROL
        && state_reg.wdata[SWT_CTL_WATCHDOG])
      state_next.active = 1'b1;
    // apb reads
    if (setup && !pwrite)
    begin
      unique case (paddr)
        SWT_APB_ACCESS: state_next.prdata = {13'h0000, state_reg.idx, state_reg.wr,
                                             state_reg.wdata};
        SWT_APB_RESULT: state_next.prdata = {16'h0000, state_reg.result};
        SWT_APB_STATUS: state_next.prdata = {28'h0000000, state_reg.active, link.wd_irq,
                                             state_reg.rst_seen, state_reg.done};
        SWT_APB_SYSCTL: state_next.prdata = {30'h00000000, state_reg.dbg, state_reg.pd};
        default:        state_next.prdata = 32'h00000000;
      endcase
    end
    // apb writes
    if (wr_en && paddr == SWT_APB_ACCESS)
    begin
      state_next.req = 1'b1;
      state_next.done = 1'b0;
      state_next.wr = pwdata[SWT_ACC_WR_BIT];
      state_next.idx = pwdata[SWT_ACC_IDX_LO+1:SWT_ACC_IDX_LO];
      if (pwdata[SWT_ACC_IDX_LO+1:SWT_ACC_IDX_LO] == SWT_IDX_CONTROL)
        state_next.wdata = pwdata[15:0] & SWT_CTL_WMASK;
      else
        state_next.wdata = pwdata[15:0];
    end
    if (wr_en && paddr == SWT_APB_STATUS && pwdata[SWT_ST_RST_SEEN])
      state_next.rst_seen = 1'b0;
    if (wr_en && paddr == SWT_APB_SYSCTL)
    begin
      state_next.pd = pwdata[SWT_SC_PD];
      state_next.dbg = pwdata[SWT_SC_DBG];
    end
    // reset event wins over its clear
    if (link.wd_reset_req)
      state_next.rst_seen = 1'b1;
  end

  // state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // outputs
  assign prdata          = state_reg.prdata;
  assign pready          = state_reg.pready;
  assign pslverr         = 1'b0;
  assign link.acc_req    = state_reg.req;
  assign link.acc_wr     = state_reg.wr;
  assign link.acc_idx    = state_reg.idx;
  assign link.acc_wdata  = state_reg.wdata;
  assign link.lf_clk     = state_reg.lf;
  assign link.powerdown  = state_reg.pd;
  assign link.debug_halt = state_reg.dbg;
  assign link.sys_rst    = state_reg.sys_rst;

endmodule

// file: bench/swt_assertions.sv
`timescale 1ns/1ps
module swt_assertions
(
  // system
  input wire logic        clk,
  input wire logic        rst_b,
  // link signals
  input wire logic        acc_req,
  input wire logic        acc_wr,
  input wire logic [1:0]  acc_idx,
  input wire logic [15:0] acc_wdata,
  input wire logic        acc_ack,
  input wire logic        sys_rst,
  input wire logic        wd_reset_req,
  input wire logic        wd_irq
);
  logic [8:0] ctl_reg;
  logic       lock_reg;

  // shadow of control and watchdog lock, frozen once watchdog is entered
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_reg  <= 9'h000;
      lock_reg <= 1'b0;
    end
    else if (acc_req && acc_wr && acc_idx == 2'h2 && !lock_reg)
    begin
      ctl_reg  <= acc_wdata[8:0];
      lock_reg <= acc_wdata[5];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // service write on the link
  sequence svc_wr;
    acc_req && acc_wr && acc_idx == 2'h3;
  endsequence
  // reset request followed by a one-cycle system reset
  sequence rst_pulse;
    wd_reset_req ##1 sys_rst ##1 !sys_rst;
  endsequence

  // link handshake
  chk_ack_follows_req: assert property (acc_req |=> acc_ack && !acc_req)
    else $error("ack missing after request");
  chk_ack_has_cause: assert property (acc_ack |-> $past(acc_req))
    else $error("ack without request");
  chk_sysrst_pulse: assert property (wd_reset_req |-> rst_pulse)
    else $error("system reset pulse wrong");
  // watchdog and timer events
  chk_zero_service: assert property (
    svc_wr ##0 (lock_reg && ctl_reg[4] && acc_wdata[7:0] == 8'h00) |-> ##[1:3] wd_reset_req)
    else $error("zero service gave no reset");
  chk_no_reset_normal: assert property (!lock_reg |-> !wd_reset_req)
    else $error("reset request outside watchdog mode");
  chk_irq_not_reset: assert property (lock_reg && ctl_reg[1] && !ctl_reg[4] |-> !wd_reset_req)
    else $error("reset while irq option set");
  chk_wd_no_irq: assert property (lock_reg && !ctl_reg[1] |-> !$rose(wd_irq))
    else $error("irq while reset option set");
  chk_disabled_quiet: assert property (
    !ctl_reg[7] && !ctl_reg[5] && !$past(ctl_reg[7]) |-> !$rose(wd_irq))
    else $error("event while disabled");
  chk_clear_drops_irq: assert property (
    svc_wr ##0 (!ctl_reg[5] && !ctl_reg[7]) |-> ##[1:3] !wd_irq)
    else $error("clear left irq pending");
endmodule

// file: bench/swt_test.sv
`timescale 1ns/1ps
module swt_test
  import swt_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic [31:0] rd;
  logic [31:0] r;
  logic [15:0] c1;
  logic [7:0]  sd;
  logic        wd_act;
  int          error_cnt;
  int          tests_run;
  int          i;

  swt_if lnk();
  swt_ctrl #(.LF_HALF_CYC(4)) i_swt_ctrl (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .link(lnk));
  swt_device i_swt_device (.clk(clk), .rst_b(rst_b), .link(lnk), .wd_active(wd_act));
  swt_assertions i_swt_assertions (.clk(clk), .rst_b(rst_b), .acc_req(lnk.acc_req),
    .acc_wr(lnk.acc_wr), .acc_idx(lnk.acc_idx), .acc_wdata(lnk.acc_wdata),
    .acc_ack(lnk.acc_ack), .sys_rst(lnk.sys_rst), .wd_reset_req(lnk.wd_reset_req),
    .wd_irq(lnk.wd_irq));

  // clock
  always #4 clk = ~clk;

  // one apb transfer, waits for pready; only the bench watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // device register access through the controller
  task automatic acc(input logic w, input logic [1:0] x, input logic [15:0] d);
    apb(1'b1, SWT_APB_ACCESS, {13'h0000, x, w, d});
    do
    begin
      apb(1'b0, SWT_APB_STATUS, 32'h0);
    end while (rd[SWT_ST_DONE] !== 1'b1);
    apb(1'b0, SWT_APB_RESULT, 32'h0);
  endtask

  task automatic wr(input logic [1:0] x, input logic [15:0] d);
    acc(1'b1, x, d);
  endtask

  task automatic rdr(input logic [1:0] x);
    acc(1'b0, x, 16'h0000);
  endtask

  task automatic stat;
    apb(1'b0, SWT_APB_STATUS, 32'h0);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic por;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  // next expected service value, galois left shift
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], 1'b0} ^ (s[7] ? 8'h63 : 8'h00);
  endfunction

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog against hangs
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    r = $urandom(32'h5a6f);
    por;
    rdr(2'h0);
    check(rd[15:0], SWT_RELOAD_RST);
    check(wd_act, 1'b0);
    rdr(2'h1);
    check(rd[15:0], SWT_COUNT_RST);
    wr(2'h1, 16'h1234);
    rdr(2'h1);
    check(rd[15:0], SWT_COUNT_RST);
    wr(2'h2, 16'hfe00);
    rdr(2'h2);
    check(rd[15:0], 16'h0000);
    for (i = 0; i < 3; i++)
    begin
      r = $urandom;
      wr(2'h0, r[15:0]);
      rdr(2'h0);
      check(rd[15:0], r[15:0]);
    end
    wr(2'h3, 16'h0000);
    repeat (40) @(posedge clk);
    rdr(2'h1);
    check(rd[15:0], r[15:0]);
    // direction and every prescaler code
    for (i = 0; i < 4; i++)
    begin
      wr(2'h0, 16'h0100);
      wr(2'h3, 16'h0000);
      wr(2'h2, {7'h00, i[0], 4'hc, i[1:0], 2'h0});
      rdr(2'h1);
      c1 = rd[15:0];
      repeat (40) @(posedge clk);
      rdr(2'h1);
      check(rd[15:0] > c1, i[0]);
      check(rd[15:0] != c1, 1'b1);
    end
    // free-running wrap, periodic reload, irq clear
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'h0002);
    wr(2'h3, 16'h0000);
    wr(2'h2, 16'h0080);
    repeat (80) @(posedge clk);
    rdr(2'h1);
    check(rd[15:0] > 16'hff00, 1'b1);
    stat;
    check(rd[SWT_ST_IRQ], 1'b1);
    wr(2'h2, 16'h00c0);
    // restart from the reload value so the periodic count stays at or below 2
    wr(2'h3, 16'h0000);
    repeat (80) @(posedge clk);
    rdr(2'h1);
    check(rd[15:0] <= 16'h0002, 1'b1);
    wr(2'h2, 16'h0000);
    wr(2'h3, 16'h0055);
    stat;
    check(rd[SWT_ST_IRQ], 1'b0);
    // power-down stop, power-down run, debug halt
    wr(2'h0, 16'h0100);
    wr(2'h3, 16'h0000);
    for (i = 0; i < 3; i++)
    begin
      wr(2'h2, i == 0 ? 16'h0081 : 16'h0080);
      apb(1'b1, SWT_APB_SYSCTL, i == 2 ? 32'h2 : 32'h1);
      rdr(2'h1);
      c1 = rd[15:0];
      repeat (40) @(posedge clk);
      rdr(2'h1);
      check(rd[15:0] == c1, i != 1);
    end
    apb(1'b1, SWT_APB_SYSCTL, 32'h0);
    // secure bit outside watchdog mode: any clear value is accepted
    wr(2'h2, 16'h0090);
    wr(2'h3, 16'h005a);
    stat;
    check(rd[SWT_ST_RST_SEEN], 1'b0);
    // secure service sequence from a random seed
    por;
    r = $urandom;
    sd = r[7:0] | 8'h01;
    wr(2'h0, 16'h0040);
    wr(2'h3, {8'h00, sd});
    wr(2'h2, 16'h00b2);
    for (i = 0; i < 3; i++)
    begin
      repeat (80) @(posedge clk);
      wr(2'h3, {8'h00, sd});
      sd = lfsr_next(sd);
      rdr(2'h1);
      check(rd[15:0] > 16'h0038, 1'b1);
    end
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'h0005);
    rdr(2'h2);
    check(rd[15:0], 16'h00b2);
    rdr(2'h0);
    check(rd[15:0], 16'h0040);
    rdr(2'h3);
    check(rd[15:0], 16'h0000);
    stat;
    check(rd[SWT_ST_RST_SEEN], 1'b0);
    check(rd[SWT_ST_ACTIVE], 1'b1);
    check(wd_act, 1'b1);
    wr(2'h3, {8'h00, ~sd});
    stat;
    check(rd[SWT_ST_RST_SEEN], 1'b1);
    rdr(2'h2);
    check(rd[15:0], 16'h00b2);
    // zero seed
    por;
    wr(2'h3, 16'h0000);
    wr(2'h2, 16'h00b2);
    wr(2'h3, 16'h0000);
    stat;
    check(rd[SWT_ST_RST_SEEN], 1'b1);
    // expiry gives reset or irq, services hold it off
    for (i = 0; i < 2; i++)
    begin
      por;
      wr(2'h0, 16'h0006);
      wr(2'h3, 16'h0001);
      wr(2'h2, i[0] ? 16'h00a2 : 16'h00a0);
      repeat (8)
      begin
        repeat (16) @(posedge clk);
        wr(2'h3, 16'h0000);
      end
      stat;
      check(rd[2:1], 2'b00);
      repeat (100) @(posedge clk);
      stat;
      check(rd[2:1], i[0] ? 2'b10 : 2'b01);
    end
    print_verdict;
  end
endmodule
